// ===== design/scc_pkg.sv
// package: register map, field layout and timing of the clock/control slice
package scc_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_PLL_REF = 8'h05;
    localparam logic [7:0] ADDR_OUT_LO = 8'h06;
    localparam logic [7:0] ADDR_OUT_HI = 8'h07;
    localparam logic [7:0] ADDR_WDOG = 8'h08;
    localparam logic [7:0] ADDR_I2C_IN = 8'h09;

    // ------------------------------------------------------------------
    // reset values and writable masks
    // ------------------------------------------------------------------
    localparam logic [7:0] PLL_REF_RST = 8'h03;
    localparam logic [7:0] OUT_LO_RST = 8'h41;
    localparam logic [7:0] OUT_HI_RST = 8'h28;
    localparam logic [7:0] WDOG_RST = 8'hfe;
    localparam logic [7:0] I2C_IN_RST = 8'h1e;
    localparam logic [7:0] PLL_REF_WMASK = 8'h78;
    localparam logic [7:0] FULL_WMASK = 8'hff;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int REF_DIV_LSB = 4;
    localparam int OSC_SEL_BIT = 3;
    localparam int FAST_DIV_LSB = 5;
    localparam int WD_TIMER_LSB = 1;
    localparam int WD_OFF_BIT = 0;
    localparam int LOCK_BIT = 7;
    localparam int HOLD_LSB = 4;

    // ------------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------------
    localparam logic [2:0] REF_DIV_1 = 3'h0;
    localparam logic [2:0] REF_DIV_8 = 3'h3;
    localparam logic [2:0] FAST_DIV_16 = 3'h4;
    localparam logic [2:0] MODE_AON = 3'h3;
    localparam logic [2:0] HOLD_FIELD_MAX = 3'h7;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int MS_PER_S = 1000;
    localparam int WD_UNIT_MS = 2;
    localparam int WD_UNIT_CYC_DEF = WD_UNIT_MS * (CLK_HZ / MS_PER_S);
    localparam int HOLD_UNIT_NS = 50;
    localparam int HOLD_UNIT_CYC =
        (HOLD_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_DEPTH = 7 * HOLD_UNIT_CYC;
    localparam int FILT_UNIT_NS = 5;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic remote;
        logic [7:0] addr;
        logic [7:0] wdata;
    } scc_reg_req_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } scc_i2c_t;

endpackage

// ===== design/scc_frac_div.sv
// fractional m/n divider producing the sensor reference clock
`timescale 1ns/1ps
module scc_frac_div
    import scc_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic src_tick_i,
    input wire logic [2:0] fast_div_i,
    input wire logic [4:0] mult_i,
    input wire logic [7:0] divisor_i,
    output logic clk_o
);

    // ------------------------------------------------------------------
    // source prescaler
    // ------------------------------------------------------------------
    logic [3:0] pre_r;
    logic [3:0] pre_last;
    logic hs_tick;
    logic [8:0] acc_r;
    logic [8:0] sum;

    // codes above divide-by-16 are treated as divide-by-16
    assign pre_last = (fast_div_i <= FAST_DIV_16) ?
        4'((5'h1 << fast_div_i) - 5'h1) : 4'hf; // [R3]
    assign hs_tick = src_tick_i && (pre_r >= pre_last);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pre_r <= 4'h0;
        end else if (hs_tick) begin
            pre_r <= 4'h0;
        end else if (src_tick_i) begin
            pre_r <= pre_r + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // accumulator: one toggle per n/(2m) source ticks, so f = src*m/n
    // ------------------------------------------------------------------
    assign sum = acc_r + {3'h0, mult_i, 1'b0};

    // settings act live, no reset needed after a change
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            acc_r <= 9'h000;
            clk_o <= 1'b0;
        end else if (mult_i == 5'h00) begin
            acc_r <= 9'h000; // [R5]
        end else if (hs_tick) begin
            if (sum >= {1'b0, divisor_i}) begin
                acc_r <= sum - {1'b0, divisor_i}; // [R4] [R17]
                clk_o <= ~clk_o;
            end else begin
                acc_r <= sum;
            end
        end
    end

    sequence s_off_two;
        mult_i == 5'h00 ##1 mult_i == 5'h00;
    endsequence

    a_off_static: assert property ( // [R5]
        @(posedge clk_i) disable iff (srst_i)
        s_off_two |-> $stable(clk_o))
        else $error("reference clock moved while multiplier is zero");

    a_toggle_cause: assert property ( // [R4]
        @(posedge clk_i) disable iff (srst_i)
        $changed(clk_o) |-> $past(hs_tick) && $past(mult_i) != 5'h00)
        else $error("reference clock toggled without a source tick");

endmodule

// ===== design/scc_cfg_top.sv
// clock, watchdog and i2c input configuration slice with its logic
//
// Behaviour
// [R1] reference input divided by 1, 2, 4 or 8
// [R2] oscillator select picks low or high range
// [R3] fast source divided by 1 to 16
// [R4] output clock is source times m over n
// [R5] zero multiplier holds output clock static
// [R6] software keeps output clock below 100 mhz
// [R7] software never writes a zero divisor
// [R8] watchdog timeout is field times 2 ms
// [R9] enabled watchdog aborts overlong channel transactions
// [R10] disable bit set stops the watchdog
// [R11] lock bit refuses remote writes to registers
// [R12] lock leaves pass-through target accesses alone
// [R13] data input held field times 50 ns
// [R14] glitches up to depth times 5 ns dropped
// [R15] always-on mode uses the internal oscillator
// [R16] fields read back last write or reset
// [R17] divider changes act without a reset
`timescale 1ns/1ps
module scc_cfg_top
    import scc_pkg::*;
#(
    parameter int unsigned WD_UNIT_CYC = WD_UNIT_CYC_DEF
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire scc_reg_req_t req_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output logic wr_refused_o,
    input wire logic ext_ref_clock_in_i,
    input wire logic fc_rate_tick_i,
    input wire logic [2:0] mode_i,
    input wire logic ext_clk_found_i,
    output logic ref_tick_o,
    output logic osc_ref_used_o,
    output logic osc_ref_select_o,
    output logic sensor_ref_clock_out_o,
    input wire logic ctrl_busy_i,
    output logic ctrl_abort_o,
    input wire scc_i2c_t i2c_pins_i,
    output scc_i2c_t i2c_in_o
);

    // ------------------------------------------------------------------
    // registers and field views
    // ------------------------------------------------------------------
    logic [7:0] pll_ref_r;
    logic [7:0] out_lo_r;
    logic [7:0] out_hi_r;
    logic [7:0] wdog_r;
    logic [7:0] i2c_in_r;
    logic lock;
    logic wd_off;
    logic [6:0] wd_field;
    logic [2:0] ref_div;
    logic [2:0] hold_f;
    logic [3:0] depth_f;
    logic wr_ok;

    assign lock = i2c_in_r[LOCK_BIT];
    assign wd_off = wdog_r[WD_OFF_BIT];
    assign wd_field = wdog_r[WD_TIMER_LSB +: 7];
    assign ref_div = pll_ref_r[REF_DIV_LSB +: 3];
    assign hold_f = i2c_in_r[HOLD_LSB +: 3];
    assign depth_f = i2c_in_r[3:0];

    function automatic logic [2:0] reg_sel(input logic [7:0] a);
        if (a == ADDR_PLL_REF) begin
            return 3'h1;
        end else if (a == ADDR_OUT_LO) begin
            return 3'h2;
        end else if (a == ADDR_OUT_HI) begin
            return 3'h3;
        end else if (a == ADDR_WDOG) begin
            return 3'h4;
        end else if (a == ADDR_I2C_IN) begin
            return 3'h5;
        end else begin
            return 3'h0;
        end
    endfunction

    // only writes to these registers are gated; pass-through traffic to
    // local bus targets never reaches this port
    assign wr_ok = req_i.wr && !(req_i.remote && lock); // [R11] [R12]

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pll_ref_r <= PLL_REF_RST;
            out_lo_r <= OUT_LO_RST;
            out_hi_r <= OUT_HI_RST;
            wdog_r <= WDOG_RST;
            i2c_in_r <= I2C_IN_RST;
        end else if (wr_ok) begin
            case (reg_sel(req_i.addr))
                3'h1: pll_ref_r <= (req_i.wdata & PLL_REF_WMASK) |
                    (pll_ref_r & ~PLL_REF_WMASK); // [R16]
                3'h2: out_lo_r <= req_i.wdata & FULL_WMASK;
                3'h3: out_hi_r <= req_i.wdata;
                3'h4: wdog_r <= req_i.wdata;
                3'h5: i2c_in_r <= req_i.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wr_refused_o <= 1'b0;
        end else begin
            wr_refused_o <= req_i.wr && req_i.remote && lock; // [R11]
        end
    end

    // read data lands one cycle after the request; unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= req_i.rd;
            if (req_i.rd) begin
                case (reg_sel(req_i.addr))
                    3'h1: rdata_o <= pll_ref_r; // [R16]
                    3'h2: rdata_o <= out_lo_r;
                    3'h3: rdata_o <= out_hi_r;
                    3'h4: rdata_o <= wdog_r;
                    3'h5: rdata_o <= i2c_in_r;
                    default: rdata_o <= 8'h00;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // reference input divider and oscillator selection
    // ------------------------------------------------------------------
    logic [2:0] ref_sync_r;
    logic ref_lvl_r;
    logic ref_edge;
    logic [2:0] ref_cnt_r;
    logic [2:0] ref_last;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ref_sync_r <= 3'h0;
            ref_lvl_r <= 1'b0;
        end else begin
            ref_sync_r <= {ref_sync_r[1:0], ext_ref_clock_in_i};
            if (ref_sync_r[1] == ref_sync_r[2]) begin
                ref_lvl_r <= ref_sync_r[2];
            end
        end
    end

    assign ref_edge = (ref_sync_r[1] == ref_sync_r[2]) && ref_sync_r[2] &&
        !ref_lvl_r;
    // reserved codes fall back to divide-by-1
    assign ref_last = (ref_div <= REF_DIV_8) ?
        3'((4'h1 << ref_div[1:0]) - 4'h1) : 3'h0; // [R1]

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ref_cnt_r <= 3'h0;
            ref_tick_o <= 1'b0;
        end else begin
            ref_tick_o <= ref_edge && (ref_cnt_r >= ref_last); // [R1]
            if (ref_edge) begin
                ref_cnt_r <= (ref_cnt_r >= ref_last) ? 3'h0 :
                    ref_cnt_r + 3'h1;
            end
        end
    end

    assign osc_ref_used_o = (mode_i == MODE_AON) || !ext_clk_found_i; // [R15]
    assign osc_ref_select_o = pll_ref_r[OSC_SEL_BIT]; // [R2]

    // ------------------------------------------------------------------
    // sensor reference clock
    // ------------------------------------------------------------------
    scc_frac_div u_frac_div (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .src_tick_i(fc_rate_tick_i),
        .fast_div_i(out_lo_r[FAST_DIV_LSB +: 3]), // [R3]
        .mult_i(out_lo_r[4:0]), // [R4]
        .divisor_i(out_hi_r), // [R7]
        .clk_o(sensor_ref_clock_out_o)
    );

    // ------------------------------------------------------------------
    // control channel watchdog
    // ------------------------------------------------------------------
    logic [15:0] unit_cnt_r;
    logic [6:0] units_r;
    logic unit_end;

    assign unit_end = unit_cnt_r == 16'(WD_UNIT_CYC - 1);

    // a zero field is treated as one unit rather than never expiring
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            unit_cnt_r <= 16'h0000;
            units_r <= 7'h00;
            ctrl_abort_o <= 1'b0;
        end else begin
            ctrl_abort_o <= 1'b0;
            if (!ctrl_busy_i || wd_off) begin
                unit_cnt_r <= 16'h0000; // [R10]
                units_r <= 7'h00;
            end else if (unit_end) begin
                unit_cnt_r <= 16'h0000;
                if (units_r + 7'h01 >= wd_field) begin
                    units_r <= 7'h00;
                    ctrl_abort_o <= 1'b1; // [R8] [R9]
                end else begin
                    units_r <= units_r + 7'h01;
                end
            end else begin
                unit_cnt_r <= unit_cnt_r + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // i2c input conditioning: glitch filter, then data hold delay
    // ------------------------------------------------------------------
    function automatic logic [3:0] filt_cycles(input logic [3:0] d);
        return 4'((int'(d) * FILT_UNIT_NS + CLK_PERIOD_NS - 1) /
            CLK_PERIOD_NS);
    endfunction

    logic [1:0] filt_r;
    logic [3:0] filt_lim;
    logic [HOLD_DEPTH-1:0] hold_sh_r;
    logic [3:0] hold_idx;

    assign filt_lim = filt_cycles(depth_f);

    for (genvar g = 0; g < 2; g++) begin : g_line
        logic [2:0] sync_r;
        logic [3:0] cnt_r;
        logic pin;
        assign pin = g ? i2c_pins_i.scl : i2c_pins_i.sda;
        always_ff @(posedge clk_i) begin
            if (srst_i) begin
                sync_r <= 3'h7;
                cnt_r <= 4'h0;
                filt_r[g] <= 1'b1;
            end else begin
                sync_r <= {sync_r[1:0], pin};
                if (sync_r[1] == sync_r[2] && sync_r[2] != filt_r[g]) begin
                    if (cnt_r >= filt_lim) begin
                        filt_r[g] <= sync_r[2]; // [R14]
                        cnt_r <= 4'h0;
                    end else begin
                        cnt_r <= cnt_r + 4'h1;
                    end
                end else begin
                    cnt_r <= 4'h0;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            hold_sh_r <= '1;
        end else begin
            hold_sh_r <= {hold_sh_r[HOLD_DEPTH-2:0], filt_r[0]};
        end
    end

    assign hold_idx = 4'(int'(hold_f) * HOLD_UNIT_CYC - 1);
    // one continuous assignment for the whole carrier
    assign i2c_in_o = '{
        scl: filt_r[1],
        sda: (hold_f == 3'h0) ? filt_r[0] : hold_sh_r[hold_idx] // [R13]
    };

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_lock_blocks: assert property ( // [R11]
        @(posedge clk_i) disable iff (srst_i)
        req_i.wr && req_i.remote && lock |=> $stable(i2c_in_r) &&
        $stable(out_hi_r) && $stable(pll_ref_r) &&
        $stable(out_lo_r) && $stable(wdog_r) && wr_refused_o)
        else $error("remote write landed while locked");

    a_write_lands: assert property ( // [R16]
        @(posedge clk_i) disable iff (srst_i)
        req_i.wr && !req_i.remote && req_i.addr == ADDR_OUT_HI
        |=> out_hi_r == $past(req_i.wdata))
        else $error("local write did not land");

    a_reserved_kept: assert property ( // [R16]
        @(posedge clk_i) disable iff (srst_i)
        (pll_ref_r & ~PLL_REF_WMASK) == (PLL_REF_RST & ~PLL_REF_WMASK))
        else $error("reserved bits changed");

    a_wdog_off: assert property ( // [R10]
        @(posedge clk_i) disable iff (srst_i)
        $past(wd_off) |-> !ctrl_abort_o)
        else $error("abort while watchdog disabled");

    a_abort_cause: assert property ( // [R9]
        @(posedge clk_i) disable iff (srst_i)
        ctrl_abort_o |-> $past(ctrl_busy_i) && $past(unit_end))
        else $error("abort without an expired busy transaction");

    a_osc_mode: assert property ( // [R15]
        @(posedge clk_i) disable iff (srst_i)
        mode_i == MODE_AON |-> osc_ref_used_o)
        else $error("always-on mode not using oscillator");

    a_ref_div_one: assert property ( // [R1]
        @(posedge clk_i) disable iff (srst_i)
        ref_div == REF_DIV_1 && ref_edge |=> ref_tick_o)
        else $error("divide-by-1 missed an edge");

    a_hold_one: assert property ( // [R13]
        @(posedge clk_i) disable iff (srst_i)
        hold_f == 3'h1 |-> i2c_in_o.sda == $past(filt_r[0], 2))
        else $error("data hold delay wrong");

endmodule

// ===== test/scc_host_model.sv
// register requester standing in for the local or remote i2c controller
`timescale 1ns/1ps
module scc_host_model
    import scc_pkg::*;
(
    input wire logic clk_i,
    output scc_reg_req_t req_o,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i,
    input wire logic wr_refused_i
);
    // ----------------------------------------------------------------
    // one request per call, strobe held for exactly the taking edge
    // ----------------------------------------------------------------
    initial req_o = '0;

    task automatic access(input logic wr, input logic rmt,
            input logic [7:0] addr, input logic [7:0] wdata,
            output logic [7:0] rdata, output logic flag);
        @(posedge clk_i);
        #1;
        req_o = '{wr: wr, rd: !wr, remote: rmt, addr: addr, wdata: wdata};
        @(posedge clk_i);
        #1;
        rdata = rdata_i;
        flag = wr ? wr_refused_i : rvalid_i;
        // released fields must not look like the last request
        req_o = '{wr: 1'b0, rd: 1'b0, remote: !rmt, addr: ~addr,
            wdata: ~wdata};
    endtask

    // settings software must never send are dropped here
    // the bench keeps m/n choices well under the output ceiling
    task automatic write_reg(input logic rmt, input logic [7:0] addr,
            input logic [7:0] wdata, output logic refused);
        logic [7:0] unused;
        refused = 1'b0;
        if (addr == ADDR_OUT_HI && wdata == 8'h00) return;
        if (addr == ADDR_WDOG && wdata[7:1] == 7'h00) return;
        access(1'b1, rmt, addr, wdata, unused, refused);
    endtask
endmodule

// ===== test/scc_cfg_top_tb.sv
// self-checking bench for the clock, watchdog and i2c input slice
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin \
    mismatches++; $display("[FAIL] %s expected %0h seen %0h", nm, \
    exp, got); end end
module scc_cfg_top_tb;
    import scc_pkg::*;
    // ----------------------------------------------------------------
    // stimulus and instances
    // ----------------------------------------------------------------
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    scc_reg_req_t req;
    logic [7:0] rdata;
    logic rvalid, refused, ref_tick, osc_used, osc_sel, sclk, abort;
    logic ext_ref = 1'b0;
    logic fc_tick = 1'b0;
    logic [2:0] mode = 3'h0;
    logic ext_found = 1'b1;
    logic busy = 1'b0;
    scc_i2c_t pins = '{scl: 1'b1, sda: 1'b1};
    scc_i2c_t i2c_in;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;

    always #20 clk_i = ~clk_i;
    always begin
        repeat (2) @(posedge clk_i);
        #1 ext_ref = ~ext_ref;
    end

    scc_cfg_top #(.WD_UNIT_CYC(4)) dut_u (.clk_i(clk_i), .srst_i(srst_i),
        .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
        .wr_refused_o(refused), .ext_ref_clock_in_i(ext_ref),
        .fc_rate_tick_i(fc_tick), .mode_i(mode),
        .ext_clk_found_i(ext_found), .ref_tick_o(ref_tick),
        .osc_ref_used_o(osc_used), .osc_ref_select_o(osc_sel),
        .sensor_ref_clock_out_o(sclk), .ctrl_busy_i(busy),
        .ctrl_abort_o(abort), .i2c_pins_i(pins), .i2c_in_o(i2c_in));

    scc_host_model host_u (.clk_i(clk_i), .req_o(req), .rdata_i(rdata),
        .rvalid_i(rvalid), .wr_refused_i(refused));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
            input logic rmt, input logic exp_ref);
        logic r;
        host_u.write_reg(rmt, a, d, r);
        `CHK("refused pulse", exp_ref, r)
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        host_u.access(1'b0, 1'b0, a, 8'h00, d, v);
        `CHK("read valid", 1'b1, v)
        `CHK("read data", exp, d)
    endtask

    // counts rising edges of a watched output over n cycles
    task automatic count_rises(input int sel, input int n, output int c);
        logic prev;
        c = 0;
        prev = (sel == 0) ? ref_tick : sclk;
        repeat (n) begin
            @(posedge clk_i);
            #1;
            if (sel == 0 && ref_tick === 1'b1) c++;
            if (sel == 1 && sclk === 1'b1 && prev === 1'b0) c++;
            prev = sclk;
        end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        logic [7:0] rst_v [5] = '{8'h03, 8'h41, 8'h28, 8'hfe, 8'h1e};
        for (int i = 0; i < 5; i++) rd(8'h05 + 8'(i), rst_v[i]);
        rd(8'h0a, 8'h00);
        wr(8'h05, 8'hff, 1'b0, 1'b0);
        rd(8'h05, 8'h7b);
        wr(8'h08, 8'haa, 1'b0, 1'b0);
        rd(8'h08, 8'haa);
        wr(8'h07, 8'h33, 1'b1, 1'b0);
        rd(8'h07, 8'h33);
        wr(8'h09, 8'h9e, 1'b0, 1'b0);
        wr(8'h07, 8'h55, 1'b1, 1'b1);
        wr(8'h09, 8'h1e, 1'b1, 1'b1);
        rd(8'h07, 8'h33);
        wr(8'h07, 8'h44, 1'b0, 1'b0);
        rd(8'h07, 8'h44);
        wr(8'h09, 8'h1e, 1'b0, 1'b0);
        $display("test registers done");
    endtask

    task automatic t_watchdog();
        int n;
        int aborts;
        wr(8'h08, 8'h04, 1'b0, 1'b0);
        busy = 1'b1;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(posedge clk_i);
                #1;
                n++;
            end while (abort !== 1'b1 && n < 30);
            `CHK("abort delay", 8, n)
        end
        busy = 1'b0;
        wr(8'h08, 8'h05, 1'b0, 1'b0);
        busy = 1'b1;
        aborts = 0;
        repeat (40) begin
            @(posedge clk_i);
            #1;
            if (abort === 1'b1) aborts++;
        end
        `CHK("aborts when off", 0, aborts)
        busy = 1'b0;
        $display("test watchdog done");
    endtask

    task automatic t_osc();
        for (int m = 0; m < 8; m++) begin
            for (int f = 0; f < 2; f++) begin
                @(posedge clk_i);
                #1;
                mode = 3'(m);
                ext_found = 1'(f);
                #1;
                `CHK("osc used", (m == 3 || f == 0), osc_used)
            end
        end
        wr(8'h05, 8'h08, 1'b0, 1'b0);
        `CHK("osc select", 1'b1, osc_sel)
        wr(8'h05, 8'h00, 1'b0, 1'b0);
        `CHK("osc select", 1'b0, osc_sel)
        $display("test oscillator done");
    endtask

    task automatic t_ref_div();
        int c;
        int e;
        for (int code = 0; code < 5; code++) begin
            wr(8'h05, {1'b0, 3'(code), 4'h0}, 1'b0, 1'b0);
            repeat (20) @(posedge clk_i);
            count_rises(0, 128, c);
            e = (code == 4) ? 32 : (32 >> code);
            `CHK("ref ticks", 1'b1, (c >= e - 1 && c <= e + 1))
        end
        $display("test reference divider done");
    endtask

    task automatic t_sensor();
        logic [7:0] lo [5] = '{8'h01, 8'h21, 8'h01, 8'h02, 8'h81};
        logic [7:0] hi [5] = '{8'h04, 8'h04, 8'h08, 8'h08, 8'h02};
        int exp_r [5] = '{64, 32, 32, 64, 8};
        int c;
        fc_tick = 1'b1;
        for (int i = 0; i < 5; i++) begin
            wr(8'h07, hi[i], 1'b0, 1'b0);
            wr(8'h06, lo[i], 1'b0, 1'b0);
            repeat (40) @(posedge clk_i);
            count_rises(1, 256, c);
            `CHK("sensor rises", 1'b1, (c >= exp_r[i] - 1 &&
                c <= exp_r[i] + 1))
        end
        wr(8'h06, 8'h00, 1'b0, 1'b0);
        repeat (4) @(posedge clk_i);
        count_rises(1, 64, c);
        `CHK("static clock", 0, c)
        $display("test sensor clock done");
    endtask

    task automatic t_i2c();
        int ts;
        int td;
        int lows;
        pins.scl = 1'b0;
        @(posedge clk_i);
        #1 pins.scl = 1'b1;
        lows = 0;
        repeat (12) begin
            @(posedge clk_i);
            #1;
            if (i2c_in.scl !== 1'b1) lows++;
        end
        `CHK("glitch passed", 0, lows)
        for (int h = 1; h < 4; h += 2) begin
            wr(8'h09, {1'b0, 3'(h), 4'he}, 1'b0, 1'b0);
            pins = '{scl: 1'b0, sda: 1'b0};
            ts = -1;
            td = -1;
            for (int i = 0; i < 40; i++) begin
                @(posedge clk_i);
                #1;
                if (i2c_in.scl === 1'b0 && ts < 0) ts = i;
                if (i2c_in.sda === 1'b0 && td < 0) td = i;
            end
            `CHK("scl settled", 1'b1, ts >= 0)
            `CHK("sda hold", h * HOLD_UNIT_CYC, td - ts)
            pins = '{scl: 1'b1, sda: 1'b1};
            repeat (30) @(posedge clk_i);
        end
        $display("test i2c input done");
    endtask

    // ----------------------------------------------------------------
    // closing and main sequence
    // ----------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // whole run needs well under 6000 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end

    initial begin
        repeat (3) @(posedge clk_i);
        #1 srst_i = 1'b0;
        t_regs();
        t_watchdog();
        t_osc();
        t_ref_div();
        t_sensor();
        t_i2c();
        complete_run();
    end
endmodule
